/* File: logic/pafs_pkg.sv */
// Package: offsets, field layout, reset values and codes of the port A low pin mux
package pafs_pkg;

  // ----------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------
  localparam logic [7:0]  OFS_SEL_UPPER   = 8'h00;
  localparam logic [7:0]  OFS_SEL_LOWER   = 8'h04;

  // ----------------------------------------
  // Writable bit masks, all other bits read zero
  // ----------------------------------------
  localparam logic [15:0] MASK_SEL_UPPER  = 16'h555F;
  localparam logic [15:0] MASK_SEL_LOWER  = 16'hFD75;

  // ----------------------------------------
  // Values after external power-on reset
  // ----------------------------------------
  localparam logic [15:0] RST_UPPER_EXT   = 16'h4000;
  localparam logic [15:0] RST_UPPER_SGL   = 16'h0000;
  localparam logic [15:0] RST_LOWER       = 16'h0000;

  // ----------------------------------------
  // Field positions, upper register
  // ----------------------------------------
  localparam int          POS_PIN15       = 14;
  localparam int          POS_PIN14       = 12;
  localparam int          POS_PIN13       = 10;
  localparam int          POS_PIN12       = 8;
  localparam int          POS_PIN11       = 6;
  localparam int          POS_PIN10       = 4;
  localparam int          POS_PIN9        = 2;
  localparam int          POS_PIN8        = 0;

  // ----------------------------------------
  // Field positions, lower register
  // ----------------------------------------
  localparam int          POS_PIN7        = 14;
  localparam int          POS_PIN6        = 12;
  localparam int          POS_PIN5        = 10;
  localparam int          POS_PIN4        = 8;
  localparam int          POS_PIN3        = 6;
  localparam int          POS_PIN2        = 4;
  localparam int          POS_PIN1        = 2;
  localparam int          POS_PIN0        = 0;

  // ----------------------------------------
  // Final count; the strap is taken one cycle later, four cycles after reset release
  // ----------------------------------------
  localparam logic [1:0]  INIT_WAIT       = 2'd3;

  // Operating mode on the mode pins, Gray along single -> extended -> ROM invalid
  typedef enum logic [1:0] {
    PAFS_MODE_SINGLE = 2'b00,
    PAFS_MODE_EXT    = 2'b01,
    PAFS_MODE_ROMINV = 2'b11,
    PAFS_MODE_RSVD   = 2'b10
  } pafs_mode_t;

  // Effective pin function: 0 general I/O, then alternates in field order
  typedef enum logic [1:0] {
    PAFS_FN_GPIO = 2'b00,
    PAFS_FN_ALT1 = 2'b01,
    PAFS_FN_ALT2 = 2'b10,
    PAFS_FN_ALT3 = 2'b11
  } pafs_fn_t;

endpackage

/* File: logic/pafs_top.sv */
// Port A low sixteen pins: function select registers on APB and the pin multiplexer
//
// Notes on behaviour
// - Reserved bits read back as zero
// - Pin 15 bit resets one in extended
// - Pin 15: general I/O or clock out
// - Pin 14 read strobe, mode overrides
// - Pin 13 upper write strobe, mode overrides
// - Pin 12 lower write strobe, mode overrides
// - Pin 11 chip select 1, mode overrides
// - Pin 10 chip select 0, mode overrides
// - Pin 9: timer clock D, interrupt 3
// - Pin 8: timer clock C, interrupt 2
// - Pin 7: timer clock B, chip select 3
// - Pin 6: timer clock A, chip select 2
// - Pin 5: serial clock 1, DMA 1, interrupt 1
// - Pin 4: serial transmit 1 out
// - Pin 3: serial receive 1 in
// - Pin 2: serial clock 0, DMA 0, interrupt 0
// - Pin 1: serial transmit 0 out
// - Pin 0: serial receive 0 in
// - Power-on reset values follow the mode
// - Other resets keep register contents
//
// Chosen here: the APB slave port and the register addresses.
module pafs_top
  import pafs_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // Operating mode pins
  input  wire logic [1:0]  MODE_PINS,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Pads
  input  wire logic [15:0] PA_IN,
  output logic      [15:0] PA_OUT,
  output logic      [15:0] PA_OE,
  // General I/O port side
  input  wire logic [15:0] GPIO_OUT,
  input  wire logic [15:0] GPIO_OE,
  output logic      [15:0] GPIO_IN,
  // Bus and clock outputs to the pads, strobes active low
  input  wire logic        SYSTEM_CLK_OUT,
  input  wire logic        READ_STROBE_N,
  input  wire logic        UPPER_WRITE_STROBE_N,
  input  wire logic        LOWER_WRITE_STROBE_N,
  input  wire logic [3:0]  CHIP_SELECT_N,
  // Serial channels
  input  wire logic [1:0]  SERIAL_TX,
  input  wire logic [1:0]  SERIAL_CLOCK_OUT,
  input  wire logic [1:0]  SERIAL_CLOCK_OE,
  output logic      [1:0]  SERIAL_CLOCK_IN,
  output logic      [1:0]  SERIAL_RX,
  // Inputs routed to timer, interrupt and DMA logic
  output logic      [3:0]  TIMER_EXT_CLOCK,
  output logic      [3:0]  EXT_INTERRUPT,
  output logic      [1:0]  DMA_REQUEST,
  // Effective function per pin, two bits each
  output logic      [31:0] PIN_FUNCTION
);

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  logic        rst_meta_n_reg;
  logic        rst_n;
  logic [1:0]  mode_s1_reg, mode_s2_reg, mode_s3_reg;
  logic [1:0]  mode_filt_reg;
  logic [15:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [15:0] pin_filt_reg;
  pafs_mode_t  mode;
  logic [1:0]  mode_filt_next;
  logic [15:0] pin_filt_next;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_n_reg <= 1'b0;
      rst_n          <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_n          <= rst_meta_n_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_reg   <= 2'b00;
      mode_s2_reg   <= 2'b00;
      mode_s3_reg   <= 2'b00;
      mode_filt_reg <= 2'b00;
      pin_s1_reg    <= 16'h0000;
      pin_s2_reg    <= 16'h0000;
      pin_s3_reg    <= 16'h0000;
      pin_filt_reg  <= 16'h0000;
    end else begin
      mode_s1_reg   <= MODE_PINS;
      mode_s2_reg   <= mode_s1_reg;
      mode_s3_reg   <= mode_s2_reg;
      mode_filt_reg <= mode_filt_next;
      pin_s1_reg    <= PA_IN;
      pin_s2_reg    <= pin_s1_reg;
      pin_s3_reg    <= pin_s2_reg;
      pin_filt_reg  <= pin_filt_next;
    end
  end

  // A change counts only once the second and third stage agree
  assign mode_filt_next = (mode_s2_reg & ~(mode_s2_reg ^ mode_s3_reg))
                        | (mode_filt_reg & (mode_s2_reg ^ mode_s3_reg));
  assign pin_filt_next  = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                        | (pin_filt_reg & (pin_s2_reg ^ pin_s3_reg));

  // Reserved mode code decodes like extended further down
  assign mode = pafs_mode_t'(mode_filt_reg);

  // ----------------------------------------
  // Strap capture after power-on reset
  // ----------------------------------------
  // Mode pins need the synchroniser depth before they can be trusted,
  // so the bus is held off (PREADY low) until the strap is taken.
  logic [1:0]  init_cnt_reg;
  logic        init_done_reg;
  logic        strap_ext;

  // The registered filter still shows its reset value on the capture
  // edge, so the strap is read from the filter's next value instead
  assign strap_ext = (pafs_mode_t'(mode_filt_next) != PAFS_MODE_SINGLE);

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_reg  <= 2'd0;
      init_done_reg <= 1'b0;
    end else if (!init_done_reg) begin
      if (init_cnt_reg == INIT_WAIT) begin
        init_done_reg <= 1'b1;
      end else begin
        init_cnt_reg <= init_cnt_reg + 2'd1;
      end
    end
  end

  // ----------------------------------------
  // APB slave and function select registers
  // ----------------------------------------
  logic [15:0] sel_upper_reg;
  logic [15:0] sel_lower_reg;
  logic        setup_phase;
  logic        access_done;
  logic        hit_upper, hit_lower;

  // Setup is ignored until the strap is taken; the master just waits
  assign setup_phase = PSEL && !PENABLE && init_done_reg;
  assign access_done = PSEL && PENABLE && PREADY;
  // Full byte address compared, so no offset aliases onto a register
  assign hit_upper   = (PADDR == OFS_SEL_UPPER);
  assign hit_lower   = (PADDR == OFS_SEL_LOWER);

  // Only RESET_N clears these; no other reset source reaches this block.
  // contents kept otherwise
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_upper_reg <= RST_UPPER_SGL;
      sel_lower_reg <= RST_LOWER;
    end else if (!init_done_reg) begin
      if (init_cnt_reg == INIT_WAIT) begin
        sel_upper_reg <= strap_ext ? RST_UPPER_EXT : RST_UPPER_SGL;
        sel_lower_reg <= RST_LOWER;
      end
    end else if (access_done && PWRITE) begin
      if (hit_upper) begin
        sel_upper_reg <= PWDATA[15:0] & MASK_SEL_UPPER;
      end
      if (hit_lower) begin
        sel_lower_reg <= PWDATA[15:0] & MASK_SEL_LOWER;
      end
    end
  end

  // No wait state: answer registered in setup, ready in first access cycle
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PREADY  <= 1'b1;
      PSLVERR <= !(hit_upper || hit_lower);
      // upper half and reserved bits read zero
      if (!PWRITE && hit_upper) begin
        PRDATA <= {16'h0000, sel_upper_reg & MASK_SEL_UPPER};
      end else if (!PWRITE && hit_lower) begin
        PRDATA <= {16'h0000, sel_lower_reg & MASK_SEL_LOWER};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Effective function per pin
  // ----------------------------------------
  // Bus function bit overridden by mode: ROM invalid forces, single chip denies
  function automatic pafs_fn_t bus_fn(input logic sel, input pafs_mode_t m);
    case (m)
      PAFS_MODE_SINGLE: bus_fn = PAFS_FN_GPIO;
      PAFS_MODE_ROMINV: bus_fn = PAFS_FN_ALT1;
      default:          bus_fn = sel ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
    endcase
  endfunction

  // Two-bit field; reserved code and, in single chip, the bus-only code fall to GPIO
  function automatic pafs_fn_t field_fn(input logic [1:0] code, input logic rsvd11,
                                        input logic bus10, input pafs_mode_t m);
    if ((code == 2'b11) && rsvd11) begin
      field_fn = PAFS_FN_GPIO;
    end else if ((code == 2'b10) && bus10 && (m == PAFS_MODE_SINGLE)) begin
      field_fn = PAFS_FN_GPIO;
    end else begin
      field_fn = pafs_fn_t'(code);
    end
  endfunction

  // Indexed by pin number
  pafs_fn_t fn [16];

  always_comb begin
    // clock output select, no mode override
    fn[15] = sel_upper_reg[POS_PIN15] ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
    fn[14] = bus_fn(sel_upper_reg[POS_PIN14], mode);
    fn[13] = bus_fn(sel_upper_reg[POS_PIN13], mode);
    fn[12] = bus_fn(sel_upper_reg[POS_PIN12], mode);
    fn[11] = bus_fn(sel_upper_reg[POS_PIN11], mode);
    fn[10] = bus_fn(sel_upper_reg[POS_PIN10], mode);
    fn[9]  = field_fn(sel_upper_reg[POS_PIN9+:2], 1'b1, 1'b0, mode);
    // timer clock C or interrupt 2
    fn[8]  = field_fn(sel_upper_reg[POS_PIN8+:2], 1'b1, 1'b0, mode);
    // chip select 3 denied in single chip
    fn[7]  = field_fn(sel_lower_reg[POS_PIN7+:2], 1'b1, 1'b1, mode);
    // chip select 2 denied in single chip
    fn[6]  = field_fn(sel_lower_reg[POS_PIN6+:2], 1'b1, 1'b1, mode);
    // DMA request 1 denied in single chip
    fn[5]  = field_fn(sel_lower_reg[POS_PIN5+:2], 1'b0, 1'b1, mode);
    fn[4]  = sel_lower_reg[POS_PIN4] ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
    fn[3]  = sel_lower_reg[POS_PIN3] ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
    // DMA request 0 denied in single chip
    fn[2]  = field_fn(sel_lower_reg[POS_PIN2+:2], 1'b0, 1'b1, mode);
    fn[1]  = sel_lower_reg[POS_PIN1] ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
    fn[0]  = sel_lower_reg[POS_PIN0] ? PAFS_FN_ALT1 : PAFS_FN_GPIO;
  end

  // ----------------------------------------
  // Pad drive per pin
  // ----------------------------------------
  // Alternate output of each pin when its function is anything but GPIO
  logic [15:0] alt_out;
  logic [15:0] alt_oe;
  logic [15:0] pa_out_next;
  logic [15:0] pa_oe_next;

  always_comb begin
    alt_out = 16'h0000;
    alt_oe  = 16'h0000;
    alt_out[15] = SYSTEM_CLK_OUT;
    alt_oe[15]  = 1'b1;
    alt_out[14] = READ_STROBE_N;
    alt_oe[14]  = 1'b1;
    alt_out[13] = UPPER_WRITE_STROBE_N;
    alt_oe[13]  = 1'b1;
    alt_out[12] = LOWER_WRITE_STROBE_N;
    alt_oe[12]  = 1'b1;
    alt_out[11] = CHIP_SELECT_N[1];
    alt_oe[11]  = 1'b1;
    alt_out[10] = CHIP_SELECT_N[0];
    alt_oe[10]  = 1'b1;
    // Pins 7 and 6 drive only as chip selects, timer clocks are inputs
    alt_out[7]  = CHIP_SELECT_N[3];
    alt_oe[7]   = (fn[7] == PAFS_FN_ALT2);
    alt_out[6]  = CHIP_SELECT_N[2];
    alt_oe[6]   = (fn[6] == PAFS_FN_ALT2);
    // Serial clocks are two-way, steered by the serial channel
    alt_out[5]  = SERIAL_CLOCK_OUT[1];
    alt_oe[5]   = (fn[5] == PAFS_FN_ALT1) && SERIAL_CLOCK_OE[1];
    alt_out[4]  = SERIAL_TX[1];
    alt_oe[4]   = 1'b1;
    alt_out[2]  = SERIAL_CLOCK_OUT[0];
    alt_oe[2]   = (fn[2] == PAFS_FN_ALT1) && SERIAL_CLOCK_OE[0];
    alt_out[1]  = SERIAL_TX[0];
    alt_oe[1]   = 1'b1;
  end

  // General I/O keeps the port's own data and direction
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pad
      assign pa_out_next[gi] = (fn[gi] == PAFS_FN_GPIO) ? GPIO_OUT[gi] : alt_out[gi];
      assign pa_oe_next[gi]  = (fn[gi] == PAFS_FN_GPIO) ? GPIO_OE[gi]  : alt_oe[gi];
    end
  endgenerate

  // Registered pads cost one cycle of latency on every output path
  // PIN_FUNCTION shares this stage so both line up in time
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PA_OUT       <= 16'h0000;
      PA_OE        <= 16'h0000;
      PIN_FUNCTION <= 32'h0000_0000;
    end else begin
      PA_OUT <= pa_out_next;
      PA_OE  <= pa_oe_next;
      for (int i = 0; i < 16; i++) begin
        PIN_FUNCTION[2*i+:2] <= fn[i];
      end
    end
  end

  // ----------------------------------------
  // Inputs routed to peripherals
  // ----------------------------------------
  // Unselected peripheral inputs read zero
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      GPIO_IN         <= 16'h0000;
      TIMER_EXT_CLOCK <= 4'h0;
      EXT_INTERRUPT   <= 4'h0;
      DMA_REQUEST     <= 2'b00;
      SERIAL_RX       <= 2'b00;
      SERIAL_CLOCK_IN <= 2'b00;
    end else begin
      GPIO_IN            <= pin_filt_reg;
      TIMER_EXT_CLOCK[0] <= pin_filt_reg[6] && (fn[6] == PAFS_FN_ALT1);
      TIMER_EXT_CLOCK[1] <= pin_filt_reg[7] && (fn[7] == PAFS_FN_ALT1);
      TIMER_EXT_CLOCK[2] <= pin_filt_reg[8] && (fn[8] == PAFS_FN_ALT1);
      TIMER_EXT_CLOCK[3] <= pin_filt_reg[9] && (fn[9] == PAFS_FN_ALT1);
      EXT_INTERRUPT[0]   <= pin_filt_reg[2] && (fn[2] == PAFS_FN_ALT3);
      EXT_INTERRUPT[1]   <= pin_filt_reg[5] && (fn[5] == PAFS_FN_ALT3);
      EXT_INTERRUPT[2]   <= pin_filt_reg[8] && (fn[8] == PAFS_FN_ALT2);
      EXT_INTERRUPT[3]   <= pin_filt_reg[9] && (fn[9] == PAFS_FN_ALT2);
      DMA_REQUEST[0]     <= pin_filt_reg[2] && (fn[2] == PAFS_FN_ALT2);
      DMA_REQUEST[1]     <= pin_filt_reg[5] && (fn[5] == PAFS_FN_ALT2);
      SERIAL_RX[0]       <= pin_filt_reg[0] && (fn[0] == PAFS_FN_ALT1);
      SERIAL_RX[1]       <= pin_filt_reg[3] && (fn[3] == PAFS_FN_ALT1);
      SERIAL_CLOCK_IN[0] <= pin_filt_reg[2] && (fn[2] == PAFS_FN_ALT1);
      SERIAL_CLOCK_IN[1] <= pin_filt_reg[5] && (fn[5] == PAFS_FN_ALT1);
    end
  end

endmodule

/* File: sim/pafs_checker.sv */
// Checker: bus handshake and pin mux properties of the port A low selector
module pafs_checker (
  // Clock, reset and mode
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic [1:0]  MODE_PINS,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Pads and routing
  input wire logic [15:0] PA_OUT,
  input wire logic [15:0] PA_OE,
  input wire logic        SYSTEM_CLK_OUT,
  input wire logic [1:0]  SERIAL_TX,
  input wire logic [1:0]  SERIAL_RX,
  input wire logic [31:0] PIN_FUNCTION
);
  timeunit 1ns;
  timeprecision 1ns;
  import pafs_pkg::*;

  logic [4:0] up_cnt;
  logic       warm;
  logic       mapped;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Slave holds off until init is done, so timing checks wait this out
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      up_cnt <= 5'h00;
    end else if (!warm) begin
      up_cnt <= up_cnt + 5'h01;
    end
  end
  assign warm   = (up_cnt == 5'h1F);
  assign mapped = (PADDR == OFS_SEL_UPPER) || (PADDR == OFS_SEL_LOWER);

  sequence setup_s;
    warm && PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  answer_time_a: assert property (setup_s ##1 access_s |-> PREADY)
    else $error("no ready in first access cycle");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  ready_access_a: assert property (PREADY |-> access_s)
    else $error("ready outside an access cycle");
  unmapped_err_a: assert property (PREADY |-> (PSLVERR == !mapped))
    else $error("error flag does not match address decode");
  upper_reserved_a: assert property (PREADY && !PWRITE && PADDR == OFS_SEL_UPPER
    |-> (PRDATA & ~{16'h0000, MASK_SEL_UPPER}) == 32'h0000_0000)
    else $error("reserved bits of upper select read nonzero");
  lower_reserved_a: assert property (PREADY && !PWRITE && PADDR == OFS_SEL_LOWER
    |-> (PRDATA & ~{16'h0000, MASK_SEL_LOWER}) == 32'h0000_0000)
    else $error("reserved bits of lower select read nonzero");
  clock_out_a: assert property (PIN_FUNCTION[31:30] == PAFS_FN_ALT1
    |-> PA_OE[15] && PA_OUT[15] == $past(SYSTEM_CLK_OUT))
    else $error("pin 15 does not carry clock out");
  tx_route_a: assert property (PIN_FUNCTION[3:2] == PAFS_FN_ALT1
    |-> PA_OE[1] && PA_OUT[1] == $past(SERIAL_TX[0]))
    else $error("pin 1 does not carry transmit 0");
  single_gpio_a: assert property ((warm && MODE_PINS == PAFS_MODE_SINGLE)[*8]
    |-> PIN_FUNCTION[29:20] == 10'h000 && PIN_FUNCTION[15:14] != PAFS_FN_ALT2
        && PIN_FUNCTION[13:12] != PAFS_FN_ALT2 && PIN_FUNCTION[11:10] != PAFS_FN_ALT2
        && PIN_FUNCTION[5:4] != PAFS_FN_ALT2)
    else $error("bus function active in single chip mode");
  rominv_strobe_a: assert property ((warm && MODE_PINS == PAFS_MODE_ROMINV)[*8]
    |-> PIN_FUNCTION[29:20] == 10'h155)
    else $error("bus strobes not forced in ROM invalid mode");
  rx_gated_a: assert property ((PIN_FUNCTION[1:0] == PAFS_FN_GPIO)[*6]
    |-> SERIAL_RX[0] == 1'b0)
    else $error("receive 0 not gated while pin 0 is general I/O");
endmodule

bind pafs_top pafs_checker u_pafs_checker (.SYS_CLK, .RESET_N, .MODE_PINS, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .PA_OUT, .PA_OE, .SYSTEM_CLK_OUT, .SERIAL_TX,
  .SERIAL_RX, .PIN_FUNCTION);

/* File: sim/testbench.sv */
// Testbench: registers, mode overrides and pad routing of the port A low selector
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pafs_pkg::*;

  typedef struct {
    logic [7:0]  addr;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [15:0] fn;
  } pafs_row_t;

  logic        clk;
  logic        rst_n;
  logic [1:0]  mode;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pa_in;
  logic [15:0] pa_out;
  logic [15:0] pa_oe;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe;
  logic [15:0] gpio_in;
  logic [7:0]  cnt = 8'h00;
  logic [3:0]  tmr_clk;
  logic [3:0]  ext_irq;
  logic [1:0]  dma_req;
  logic [1:0]  sck_in;
  logic [1:0]  ser_tx;
  logic [1:0]  ser_rx;
  logic [31:0] pin_fn;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          checks;
  // legal field codes only
  // Address, write data, read back, effective function of that half
  pafs_row_t   rows [8] = '{
    '{8'h00, 16'hFFFA, 16'h555A, 16'h555A}, '{8'h00, 16'h0006, 16'h0006, 16'h0006},
    '{8'h04, 16'hAFFF, 16'hAD75, 16'hAD75}, '{8'h04, 16'h6800, 16'h6800, 16'h6800},
    '{8'h00, 16'h0009, 16'h0009, 16'h0009}, '{8'h04, 16'h9410, 16'h9410, 16'h9410},
    '{8'h00, 16'h5550, 16'h5550, 16'h5550}, '{8'h00, 16'h4000, 16'h4000, 16'h4000}};

  pafs_top u_pafs_top (
    .SYS_CLK              (clk),
    .RESET_N              (rst_n),
    .MODE_PINS            (mode),
    .PSEL                 (psel),
    .PENABLE              (penable),
    .PWRITE               (pwrite),
    .PADDR                (paddr),
    .PWDATA               (pwdata),
    .PRDATA               (prdata),
    .PREADY               (pready),
    .PSLVERR              (pslverr),
    .PA_IN                (pa_in),
    .PA_OUT               (pa_out),
    .PA_OE                (pa_oe),
    .GPIO_OUT             (gpio_out),
    .GPIO_OE              (gpio_oe),
    .GPIO_IN              (gpio_in),
    .SYSTEM_CLK_OUT       (cnt[0]),
    .READ_STROBE_N        (cnt[1]),
    .UPPER_WRITE_STROBE_N (cnt[2]),
    .LOWER_WRITE_STROBE_N (cnt[3]),
    .CHIP_SELECT_N        (cnt[7:4]),
    .SERIAL_TX            (ser_tx),
    .SERIAL_CLOCK_OUT     (cnt[1:0]),
    .SERIAL_CLOCK_OE      (cnt[5:4]),
    .SERIAL_CLOCK_IN      (sck_in),
    .SERIAL_RX            (ser_rx),
    .TIMER_EXT_CLOCK      (tmr_clk),
    .EXT_INTERRUPT        (ext_irq),
    .DMA_REQUEST          (dma_req),
    .PIN_FUNCTION         (pin_fn)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Busy pattern on the routed outputs so pin routing is really exercised
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
  end

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the extra leading edge keeps psel from being set twice in a step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask

  task automatic wait_fn(input logic [31:0] exp, input logic [31:0] msk);
    int n;
    n = 0;
    while ((pin_fn & msk) !== exp && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(pin_fn & msk, exp);
    if ((pin_fn & msk) !== exp) close_out();
  endtask

  task automatic do_reset(input pafs_mode_t m);
    rst_n <= 1'b0;
    mode  <= m;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (15) @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    mode = PAFS_MODE_EXT;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pa_in = 16'h0000;
    gpio_out = 16'h0000;
    gpio_oe = 16'h0000;
    ser_tx = 2'b00;
    fails = 0;
    checks = 0;
    @(posedge clk);
    do_reset(PAFS_MODE_EXT);
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b1, {16'hFFFF, rows[i].wd});
      apb(rows[i].addr, 1'b0, 32'h0000_0000);
      check(rd, {16'h0000, rows[i].rd});
      check(32'(err), 32'h0000_0000);
      wait_fn(rows[i].addr == 8'h00 ? {rows[i].fn, 16'h0000} : {16'h0000, rows[i].fn},
              rows[i].addr == 8'h00 ? 32'hFFFF_0000 : 32'h0000_FFFF);
    end
    // Unmapped place: refused, no aliasing onto the upper select register
    apb(8'h08, 1'b1, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
    apb(8'h08, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(OFS_SEL_UPPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_4000);
    // Mode overrides on live mode pins
    apb(OFS_SEL_UPPER, 1'b1, 32'h0000_5550);
    apb(OFS_SEL_LOWER, 1'b1, 32'h0000_A800);
    wait_fn(32'h5550_A800, 32'hFFFF_FFFF);
    mode <= PAFS_MODE_SINGLE;
    wait_fn(32'h4000_0000, 32'hFFFF_FFFF);
    mode <= PAFS_MODE_RSVD;
    wait_fn(32'h5550_A800, 32'hFFFF_FFFF);
    mode <= PAFS_MODE_ROMINV;
    apb(OFS_SEL_UPPER, 1'b1, 32'h0000_0000);
    wait_fn(32'h1550_A800, 32'hFFFF_FFFF);
    // Serial routing and general I/O pass-through
    mode <= PAFS_MODE_EXT;
    apb(OFS_SEL_LOWER, 1'b1, 32'h0000_0145);
    ser_tx   <= 2'b01;
    pa_in    <= 16'h0008;
    gpio_out <= 16'h0020;
    gpio_oe  <= 16'h0024;
    repeat (8) @(posedge clk);
    check(32'({pa_out[4], pa_out[1], pa_oe[4], pa_oe[1]}), 32'h0000_0007);
    check(32'(ser_rx), 32'h0000_0002);
    check(32'({pa_out[5], pa_oe[5], pa_oe[2]}), 32'h0000_0007);
    check(32'(gpio_in), 32'h0000_0008);
    // Timer, interrupt, DMA and serial clock inputs routed from the pads
    apb(OFS_SEL_UPPER, 1'b1, 32'h0000_0009);
    apb(OFS_SEL_LOWER, 1'b1, 32'h0000_5420);
    pa_in <= 16'h03E4;
    repeat (8) @(posedge clk);
    check(32'(tmr_clk), 32'h0000_0007);
    check(32'(ext_irq), 32'h0000_0008);
    check(32'(dma_req), 32'h0000_0001);
    check(32'(sck_in), 32'h0000_0002);
    // Power-on values follow the strap
    apb(OFS_SEL_UPPER, 1'b1, 32'h0000_0001);
    do_reset(PAFS_MODE_SINGLE);
    apb(OFS_SEL_UPPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(OFS_SEL_LOWER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(OFS_SEL_UPPER, 1'b1, 32'h0000_0006);
    do_reset(PAFS_MODE_EXT);
    apb(OFS_SEL_UPPER, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_4000);
    wait_fn(32'h4000_0000, 32'hC000_0000);
    close_out();
  end
endmodule
